// ---- eets_pkg.sv ----
// constants and types for the two-wire serial memory slave
// How it works
// - sda falling while scl high starts commands
// - sda rising while scl high stops anywhere
// - stop after accepted data starts programming
// - stop after read data returns to standby
// - standby after stop or finished programming
// - receiver pulls sda low on ninth clock
// - sda changes only while scl low, msb first
// - select byte bit 0 gives the direction
// - write select bits 3..1 give address 10..8
// - read select bits 3..1 are ignored
// - select upper nibble must match type code
// - low address byte loads counter, acknowledged
// - counter advances after written and read bytes
// - reads continue while master acknowledges
// - matching write select acknowledged on ninth clock
// - programming erases to ones, then writes
// - programming finishes within 8 ms
// - one to sixteen data bytes enter page buffer
// - only address bits 3..0 advance during entry
// - bytes not entered stay unprogrammed
// - no select acknowledged while programming
// - counter ends at last entered byte
// - polling select acknowledged once programming done
// - repeated start abandons write without programming
// - write protect high refuses all modification
// - sequential read wraps from top to zero
package eets_pkg;
  localparam int          ADDR_W        = 11;
  localparam int          MEM_DEPTH     = 2048;
  localparam int          PAGE_W        = 4;
  localparam int          PAGE_BYTES    = 16;
  localparam logic [3:0]  BYTE_BITS     = 4'h8;
  localparam logic [7:0]  ERASED        = 8'hFF;
  localparam int          SEL_DIR_BIT   = 0;
  localparam int          SEL_HI_LSB    = 1;
  localparam int          SEL_CODE_LSB  = 4;
  localparam int          CLK_HZ        = 25000000;
  localparam int          PROG_TIME_MS  = 8;
  localparam int          PROG_CYC      = PROG_TIME_MS * (CLK_HZ / 1000);
  localparam int          TMR_W         = 24;
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STAT      = 8'h04;
  localparam int          CTRL_EN_BIT   = 0;
  localparam int          CTRL_WP_BIT   = 1;
  localparam logic [1:0]  CTRL_RST      = 2'h1;
  localparam int          STAT_BUSY_BIT = 0;
  localparam int          STAT_ST_LSB   = 4;
  localparam int          STAT_ADDR_LSB = 16;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_SEL     = 4'h1,
    ST_SELACK  = 4'h3,
    ST_ADDR    = 4'h2,
    ST_ADDRACK = 4'h6,
    ST_WDATA   = 4'h7,
    ST_WACK    = 4'h5,
    ST_RDATA   = 4'h4,
    ST_RACK    = 4'hC,
    ST_IGNORE  = 4'hD
  } eets_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } eets_pins_t;

  localparam eets_pins_t PINS_IDLE = 2'h3;

  typedef struct packed {
    eets_state_t           state;
    logic [3:0]            bitcnt;
    logic [7:0]            shreg;
    logic [ADDR_W-1:0]     addr;
    logic [ADDR_W-1:0]     last;
    logic [15:0][7:0]      pbuf;
    logic [15:0]           pval;
    logic                  wr_pend;
    logic                  rd_ok;
    logic                  sda_oe;
    logic                  busy;
    logic [TMR_W-1:0]      ptimer;
    logic [1:0]            ctrl;
    logic [31:0]           prdata;
    logic                  pslverr;
    eets_pins_t            pin_m;
    eets_pins_t            pin_s;
    eets_pins_t            pin_d;
    logic                  wp_m;
    logic                  wp_s;
  } eets_regs_t;
endpackage

// ---- eets_slave.sv ----
// two-wire serial memory slave with page buffer, timed programming and apb control
`timescale 1ns/1ps
module eets_slave
  import eets_pkg::*;
#(
  parameter logic [3:0] DEV_CODE   = 4'h6,     // arbitrary device-type code
  parameter int         PROG_CYC_P = PROG_CYC
) (
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic        SCL,
  input  wire logic        SDA_I,
  output logic             SDA_O,
  output logic             SDA_OE,
  input  wire logic        WP,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             BUSY
);

  localparam logic [TMR_W-1:0] PROG_LAST = TMR_W'(PROG_CYC_P - 1);
  localparam logic [TMR_W-1:0] PROG_HALF = TMR_W'(PROG_CYC_P / 2);
  localparam logic [TMR_W-1:0] PAGE_TCK  = TMR_W'(PAGE_BYTES);

  eets_regs_t        r;
  eets_regs_t        n;
  logic [7:0]        mem [0:MEM_DEPTH-1];
  logic              mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [7:0]        mem_wd;
  logic [7:0]        rd_byte;
  logic              scl_hi;
  logic              start_c;
  logic              stop_c;
  logic              scl_rise;
  logic              scl_fall;
  logic              wp_eff;
  logic              sel_match;
  logic [TMR_W-1:0]  woff;
  logic [31:0]       stat_word;

  assign rd_byte  = mem[r.addr];
  assign scl_hi   = r.pin_s.scl & r.pin_d.scl;
  assign start_c  = scl_hi & r.pin_d.sda & ~r.pin_s.sda;
  assign stop_c   = scl_hi & ~r.pin_d.sda & r.pin_s.sda;
  assign scl_rise = r.pin_s.scl & ~r.pin_d.scl;
  assign scl_fall = ~r.pin_s.scl & r.pin_d.scl;
  assign wp_eff   = r.wp_s | r.ctrl[CTRL_WP_BIT];
  assign woff     = r.ptimer - PROG_HALF;
  // type code must match; direction bit plays no part here
  assign sel_match = (r.shreg[7:SEL_CODE_LSB] == DEV_CODE)
                   & r.ctrl[CTRL_EN_BIT] & ~r.busy;

  always_comb begin
    stat_word                                = '0;
    stat_word[STAT_BUSY_BIT]                 = r.busy;
    stat_word[STAT_ST_LSB +: 4]              = r.state;
    stat_word[STAT_ADDR_LSB +: ADDR_W]       = r.addr;
  end

  always_comb begin
    n       = r;
    mem_we  = 1'b0;
    mem_wa  = '0;
    mem_wd  = '0;
    n.pin_m = '{scl: SCL, sda: SDA_I};
    n.pin_s = r.pin_m;
    n.pin_d = r.pin_s;
    n.wp_m  = WP;
    n.wp_s  = r.wp_m;

    // self-timed erase then write of the flagged page bytes
    if (r.busy) begin
      n.ptimer = r.ptimer + 1'b1;
      if (r.ptimer < PAGE_TCK) begin
        if (r.pval[r.ptimer[PAGE_W-1:0]]) begin
          mem_we = 1'b1;
          mem_wa = {r.last[ADDR_W-1:PAGE_W], r.ptimer[PAGE_W-1:0]};
          mem_wd = ERASED;
        end
      end else if (r.ptimer >= PROG_HALF && woff < PAGE_TCK) begin
        if (r.pval[woff[PAGE_W-1:0]]) begin
          mem_we = 1'b1;
          mem_wa = {r.last[ADDR_W-1:PAGE_W], woff[PAGE_W-1:0]};
          mem_wd = r.pbuf[woff[PAGE_W-1:0]];
        end
      end
      if (r.ptimer == PROG_LAST) begin
        n.busy   = 1'b0;
        n.ptimer = '0;
        n.pval   = '0;
        n.addr   = r.last;
      end
    end

    if (stop_c) begin
      n.state   = ST_IDLE;
      n.sda_oe  = 1'b0;
      n.wr_pend = 1'b0;
      if (r.wr_pend && !wp_eff && !r.busy) begin
        n.busy   = 1'b1;
        n.ptimer = '0;
      end else if (!r.busy) begin
        n.pval = '0;
      end
    end else if (start_c) begin
      n.state   = ST_SEL;
      n.bitcnt  = '0;
      n.sda_oe  = 1'b0;
      n.wr_pend = 1'b0;
      if (!r.busy) begin
        n.pval = '0;
      end
    end else if (scl_rise) begin
      case (r.state)
        ST_SEL, ST_ADDR, ST_WDATA: begin
          n.shreg  = {r.shreg[6:0], r.pin_s.sda};
          n.bitcnt = r.bitcnt + 1'b1;
        end
        ST_RDATA: begin
          n.bitcnt = r.bitcnt + 1'b1;
        end
        ST_RACK: begin
          n.rd_ok = ~r.pin_s.sda;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (r.state)
        ST_SEL: begin
          if (r.bitcnt == BYTE_BITS) begin
            if (sel_match) begin
              n.sda_oe = 1'b1;
              n.state  = ST_SELACK;
              if (!r.shreg[SEL_DIR_BIT]) begin
                n.addr[ADDR_W-1:8] = r.shreg[SEL_HI_LSB +: 3];
              end
            end else begin
              n.state = ST_IGNORE;
            end
          end
        end
        ST_SELACK: begin
          n.sda_oe = 1'b0;
          n.bitcnt = '0;
          if (r.shreg[SEL_DIR_BIT]) begin
            n.shreg  = rd_byte;
            n.addr   = r.addr + 1'b1;
            n.sda_oe = ~rd_byte[7];
            n.state  = ST_RDATA;
          end else begin
            n.state = ST_ADDR;
          end
        end
        ST_ADDR: begin
          if (r.bitcnt == BYTE_BITS) begin
            n.addr[7:0] = r.shreg;
            n.sda_oe    = 1'b1;
            n.state     = ST_ADDRACK;
          end
        end
        ST_ADDRACK: begin
          n.sda_oe = 1'b0;
          n.bitcnt = '0;
          n.state  = ST_WDATA;
        end
        ST_WDATA: begin
          if (r.bitcnt == BYTE_BITS) begin
            n.pbuf[r.addr[PAGE_W-1:0]] = r.shreg;
            n.pval[r.addr[PAGE_W-1:0]] = 1'b1;
            n.last    = r.addr;
            n.wr_pend = 1'b1;
            n.sda_oe  = 1'b1;
            n.state   = ST_WACK;
          end
        end
        ST_WACK: begin
          n.sda_oe = 1'b0;
          n.bitcnt = '0;
          n.addr[PAGE_W-1:0] = r.addr[PAGE_W-1:0] + 1'b1;
          n.state  = ST_WDATA;
        end
        ST_RDATA: begin
          if (r.bitcnt == BYTE_BITS) begin
            n.sda_oe = 1'b0;
            n.rd_ok  = 1'b0;
            n.state  = ST_RACK;
          end else begin
            n.sda_oe = ~r.shreg[6];
            n.shreg  = {r.shreg[6:0], 1'b0};
          end
        end
        ST_RACK: begin
          if (r.rd_ok) begin
            n.shreg  = rd_byte;
            n.addr   = r.addr + 1'b1;
            n.sda_oe = ~rd_byte[7];
            n.bitcnt = '0;
            n.state  = ST_RDATA;
          end else begin
            n.state = ST_IGNORE;
          end
        end
        default: begin
        end
      endcase
    end

    // apb: decode on setup, answer in access phase with no wait
    if (PSEL && !PENABLE) begin
      n.pslverr = 1'b0;
      case (PADDR)
        REG_CTRL: n.prdata = {30'h0, r.ctrl};
        REG_STAT: n.prdata = stat_word;
        default: begin
          n.prdata  = '0;
          n.pslverr = 1'b1;
        end
      endcase
    end
    if (PSEL && PENABLE && PWRITE && PADDR == REG_CTRL) begin
      n.ctrl = PWDATA[1:0];
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      r       <= '0;
      r.ctrl  <= CTRL_RST;
      r.pin_m <= PINS_IDLE;
      r.pin_s <= PINS_IDLE;
      r.pin_d <= PINS_IDLE;
    end else begin
      r <= n;
    end
  end

  // nonvolatile array stand-in, no reset
  always_ff @(posedge CLK) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign SDA_O   = 1'b0;
  assign SDA_OE  = r.sda_oe;
  assign PRDATA  = r.prdata;
  assign PSLVERR = r.pslverr;
  assign PREADY  = 1'b1;
  assign BUSY    = r.busy;

  AST_START_SEL: assert property (
    @(posedge CLK) disable iff (!RST_B)
    start_c && !stop_c |=> r.state == ST_SEL && r.bitcnt == 4'h0)
    else $error("start not taken");

  AST_STOP_IDLE: assert property (
    @(posedge CLK) disable iff (!RST_B)
    stop_c |=> r.state == ST_IDLE && !r.sda_oe)
    else $error("stop did not return to standby");

  AST_PROG_START: assert property (
    @(posedge CLK) disable iff (!RST_B)
    stop_c && r.wr_pend && !wp_eff && !r.busy |=> r.busy && r.ptimer == '0)
    else $error("programming not started");

  AST_READ_NO_PROG: assert property (
    @(posedge CLK) disable iff (!RST_B)
    stop_c && !r.wr_pend && !r.busy |=> !r.busy)
    else $error("programming without written data");

  AST_PROTECT: assert property (
    @(posedge CLK) disable iff (!RST_B)
    stop_c && wp_eff && !r.busy |=> !r.busy ##1 !mem_we)
    else $error("write protect ignored");

  AST_PROG_END: assert property (
    @(posedge CLK) disable iff (!RST_B)
    r.busy && r.ptimer == PROG_LAST |=> !r.busy && r.addr == $past(r.last))
    else $error("programming overran or counter misplaced");

  AST_NO_ACK_BUSY: assert property (
    @(posedge CLK) disable iff (!RST_B)
    r.busy && r.state == ST_SEL && scl_fall && r.bitcnt == BYTE_BITS
    |=> !r.sda_oe && r.state == ST_IGNORE)
    else $error("select acknowledged while busy");

  AST_SDA_SCL_LOW: assert property (
    @(posedge CLK) disable iff (!RST_B)
    $changed(r.sda_oe) && !$past(stop_c) && !$past(start_c) |-> !r.pin_d.scl)
    else $error("sda changed while scl high");

  AST_PAGE_FIXED: assert property (
    @(posedge CLK) disable iff (!RST_B)
    r.state == ST_WACK && scl_fall && !start_c && !stop_c
    |=> r.addr[ADDR_W-1:PAGE_W] == $past(r.addr[ADDR_W-1:PAGE_W]))
    else $error("page bits moved during entry");

  AST_ADDR_LOAD: assert property (
    @(posedge CLK) disable iff (!RST_B)
    r.state == ST_ADDR && scl_fall && r.bitcnt == BYTE_BITS && !start_c && !stop_c
    |=> r.addr[7:0] == $past(r.shreg) && r.sda_oe)
    else $error("low address byte not loaded");

  AST_SEL_ACK_WR: assert property (
    @(posedge CLK) disable iff (!RST_B)
    r.state == ST_SEL && scl_fall && r.bitcnt == BYTE_BITS && sel_match && !r.shreg[SEL_DIR_BIT]
    |=> r.sda_oe && r.state == ST_SELACK)
    else $error("write select not acknowledged");

  AST_SEL_HI_ADDR: assert property (
    @(posedge CLK) disable iff (!RST_B)
    r.state == ST_SEL && scl_fall && r.bitcnt == BYTE_BITS && sel_match && !r.shreg[SEL_DIR_BIT]
    |=> r.addr[ADDR_W-1:8] == $past(r.shreg[SEL_HI_LSB +: 3]))
    else $error("upper address bits not taken from select");

  AST_SEL_RD_ADDR: assert property (
    @(posedge CLK) disable iff (!RST_B)
    r.state == ST_SEL && scl_fall && r.bitcnt == BYTE_BITS && sel_match && r.shreg[SEL_DIR_BIT]
    |=> r.sda_oe && r.addr == $past(r.addr))
    else $error("read select moved the address counter");

  AST_SEL_WRONG: assert property (
    @(posedge CLK) disable iff (!RST_B)
    r.state == ST_SEL && scl_fall && r.bitcnt == BYTE_BITS && r.shreg[7:SEL_CODE_LSB] != DEV_CODE
    |=> !r.sda_oe && r.state == ST_IGNORE)
    else $error("foreign select acknowledged");

  AST_IGNORE_QUIET: assert property (
    @(posedge CLK) disable iff (!RST_B)
    r.state == ST_IGNORE |-> !r.sda_oe)
    else $error("sda pulled while ignoring the bus");

  AST_DATA_ACK: assert property (
    @(posedge CLK) disable iff (!RST_B)
    r.state == ST_WDATA && scl_fall && r.bitcnt == BYTE_BITS
    |=> r.sda_oe && r.wr_pend && r.last == $past(r.addr))
    else $error("data byte not buffered or acknowledged");

  AST_ACK_DROP: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (r.state == ST_ADDRACK || r.state == ST_WACK) && scl_fall
    |=> !r.sda_oe && r.state == ST_WDATA)
    else $error("acknowledge not released after ninth clock");

  AST_RD_RELEASE: assert property (
    @(posedge CLK) disable iff (!RST_B)
    r.state == ST_RDATA && scl_fall && r.bitcnt == BYTE_BITS
    |=> !r.sda_oe && r.state == ST_RACK)
    else $error("sda not released for master acknowledge");

  AST_RD_NEXT: assert property (
    @(posedge CLK) disable iff (!RST_B)
    r.state == ST_RACK && scl_fall && r.rd_ok
    |=> r.state == ST_RDATA && r.addr == $past(r.addr) + 1'b1)
    else $error("acknowledged read did not continue");

  AST_RD_END: assert property (
    @(posedge CLK) disable iff (!RST_B)
    r.state == ST_RACK && scl_fall && !r.rd_ok
    |=> r.state == ST_IGNORE && !r.sda_oe)
    else $error("read went on without master acknowledge");

  AST_ERASE_ONES: assert property (
    @(posedge CLK) disable iff (!RST_B)
    mem_we && r.ptimer < PAGE_TCK |-> mem_wd == ERASED)
    else $error("erase step wrote other than ones");

  AST_PROG_PAGE: assert property (
    @(posedge CLK) disable iff (!RST_B)
    mem_we |-> r.busy && r.pval[mem_wa[PAGE_W-1:0]]
    && mem_wa[ADDR_W-1:PAGE_W] == r.last[ADDR_W-1:PAGE_W])
    else $error("byte programmed that was not entered");

  AST_PROG_BOUND: assert property (
    @(posedge CLK) disable iff (!RST_B)
    r.busy |-> r.ptimer <= PROG_LAST)
    else $error("programming timer ran past its end");

  AST_RESTART_DROP: assert property (
    @(posedge CLK) disable iff (!RST_B)
    start_c && !r.busy |=> !r.wr_pend && r.pval == '0)
    else $error("repeated start kept pending write");

endmodule

// ---- eets_bus_master.sv ----
// two-wire bus master model driving scl and pulling sda low
`timescale 1ns/1ps
module eets_bus_master (
  input  wire logic clk,
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_oe
);
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end

  task automatic half();
    repeat (4) @(posedge clk);
  endtask

  // one scl pulse, sda set mid low phase, sampled at end of high
  task automatic put(input logic v, output logic r);
    repeat (2) @(posedge clk);
    sda_oe <= ~v;
    repeat (2) @(posedge clk);
    scl <= 1'b1;
    half();
    r = sda_in;
    scl <= 1'b0;
  endtask

  // long low phase lets a device ack release before scl rises
  task automatic start();
    repeat (2) @(posedge clk);
    sda_oe <= 1'b0;
    repeat (6) @(posedge clk);
    scl <= 1'b1;
    half();
    sda_oe <= 1'b1;
    half();
    scl <= 1'b0;
  endtask

  task automatic stop();
    repeat (2) @(posedge clk);
    sda_oe <= 1'b1;
    repeat (2) @(posedge clk);
    scl <= 1'b1;
    half();
    sda_oe <= 1'b0;
    half();
  endtask

  task automatic wbyte(input logic [7:0] b, output logic ak);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put(b[i], r);
    end
    put(1'b1, r);
    ak = ~r;
  endtask

  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++) begin
      put(1'b1, r);
      d = {d[6:0], r};
    end
    put(~mack, r);
  endtask
endmodule

// ---- tb_serial_eeprom_two_wire_slave.sv ----
// self-checking bench for the two-wire serial memory slave
`timescale 1ns/1ps
module tb_serial_eeprom_two_wire_slave;
  import eets_pkg::*;
  localparam logic [3:0] DEV  = 4'h6; // arbitrary type code
  localparam int         PROG = 400;
  logic        clk, rst_b, wp, psel, penable, pwrite, pready, pslverr, busy;
  logic        scl, m_oe, sda_o, sda_oe, sda_line;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  ref_mem [0:2047];
  int          fails, checked;

  assign sda_line = ~((sda_oe & ~sda_o) | m_oe);

  eets_slave #(.DEV_CODE(DEV), .PROG_CYC_P(PROG)) u_dut (
    .CLK(clk), .RST_B(rst_b), .SCL(scl), .SDA_I(sda_line), .SDA_O(sda_o),
    .SDA_OE(sda_oe), .WP(wp), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .BUSY(busy)
  );

  eets_bus_master u_m (.clk(clk), .sda_in(sda_line), .scl(scl), .sda_oe(m_oe));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic finish_test();
    if (fails == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    finish_test();
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (k == 16) begin
      fails++;
      finish_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic nack(input logic [7:0] sel);
    logic ak;
    u_m.start();
    u_m.wbyte(sel, ak); cmp(ak, 0);
    u_m.wbyte(8'($urandom), ak); cmp(ak, 0);
    u_m.stop();
  endtask

  task automatic wr(input logic [10:0] a, input int n, input logic prot);
    logic ak;
    logic [7:0] d;
    logic [10:0] p;
    int k;
    u_m.start();
    u_m.wbyte({DEV, a[10:8], 1'b0}, ak); cmp(ak, 1);
    u_m.wbyte(a[7:0], ak); cmp(ak, 1);
    for (k = 0; k < n; k++) begin
      d = 8'($urandom);
      p = {a[10:4], a[3:0] + 4'(k)};
      u_m.wbyte(d, ak); cmp(ak, 1);
      if (!prot) ref_mem[p] = d;
    end
    u_m.stop();
    repeat (6) @(posedge clk);
    cmp(busy, !prot);
    if (!prot) begin
      nack({DEV, 4'h1});
      for (k = 0; k < PROG && busy !== 1'b0; k++) @(posedge clk);
      cmp(busy, 0);
      if (busy !== 1'b0) finish_test();
      u_m.start();
      u_m.wbyte({DEV, 4'h1}, ak); cmp(ak, 1);
      u_m.rbyte(1'b0, d); cmp(d, ref_mem[p]);
      u_m.stop();
      repeat (6) @(posedge clk);
      cmp(busy, 0);
    end
  endtask

  task automatic rd(input logic [10:0] a, input int n);
    logic ak;
    logic [7:0] d;
    u_m.start();
    u_m.wbyte({DEV, a[10:8], 1'b0}, ak); cmp(ak, 1);
    u_m.wbyte(a[7:0], ak); cmp(ak, 1);
    u_m.start();
    u_m.wbyte({DEV, 3'($urandom), 1'b1}, ak); cmp(ak, 1);
    for (int k = 0; k < n; k++) begin
      u_m.rbyte(k < n - 1, d);
      cmp(d, ref_mem[11'(a + k)]);
    end
    u_m.stop();
    repeat (6) @(posedge clk);
    cmp(busy, 0);
  endtask

  initial begin
    logic [31:0] rdat;
    logic        er;
    logic [10:0] pg;
    rst_b = 1'b0;
    wp = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(77603));
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    cmp(sda_oe, 0); cmp(busy, 0);
    apb(1'b0, REG_CTRL, 32'h0, rdat, er);
    cmp(rdat, 32'h1); cmp(er, 0);
    apb(1'b0, 8'h08, 32'h0, rdat, er);
    cmp(rdat, 32'h0); cmp(er, 1);
    pg = {7'($urandom), 4'h0};
    wr(pg, 16, 1'b0);
    rd(pg, 16);
    wr(pg + 11'h00E, 5, 1'b0);
    rd(pg, 16);
    wr(11'h7FF, 1, 1'b0);
    wr(11'h000, 1, 1'b0);
    rd(11'h7FF, 2);
    apb(1'b0, REG_STAT, 32'h0, rdat, er);
    cmp(rdat[26:16], 32'h1);
    wp <= 1'b1;
    wr(pg, 3, 1'b1);
    wp <= 1'b0;
    apb(1'b1, REG_CTRL, 32'h3, rdat, er);
    wr(pg + 11'h003, 2, 1'b1);
    apb(1'b1, REG_CTRL, 32'h0, rdat, er);
    nack({DEV, 4'h0});
    apb(1'b1, REG_CTRL, 32'h1, rdat, er);
    rd(pg, 16);
    nack({DEV ^ 4'h8, 4'h0});
    rd(pg + 11'h005, 1);
    finish_test();
  end
endmodule
